// [common/gbw_pkg.sv]
// Types shared by the branch and word-load block
package gbw_pkg;
  typedef logic [31:0] gbw_word_t;
  typedef logic [7:0]  gbw_opc_t;
  typedef logic [6:0]  gbw_reg_t;
  typedef logic [6:0]  gbw_disp_t;
  typedef logic [1:0]  gbw_swap_t;
  typedef enum logic [3:0] {
    GBW_BR_NONE  = 4'h1,
    GBW_BR_FALSE = 4'h2,
    GBW_BR_TRUE  = 4'h4,
    GBW_BR_IMM   = 4'h8
  } gbw_br_kind_t;
endpackage

// [common/gbw_regs.svh]
// Opcodes, pipeline depths and address constants of the branch and word-load block
`ifndef GBW_REGS_SVH
`define GBW_REGS_SVH

// Operation codes
`define GBW_OP_JUMP_FALSE 8'hb4
`define GBW_OP_JUMP_TRUE  8'hb0
`define GBW_OP_JUMP_IMM   8'hb2
`define GBW_OP_WORD_LOAD  8'h07

// Branch delay in instructions, load latency in cycles
`define GBW_BR_DELAY      3
`define GBW_LD_LATENCY    3

// Displacement field: 7 bits, scaled by four
`define GBW_DISP_MSB      6
`define GBW_DISP_EXT_W    23

// Byte-order swap values
`define GBW_SWAP_LITTLE   2'h3
`define GBW_SWAP_BIG      2'h0

// I/O aperture decode, values arbitrary
`define GBW_MMIO_BASE     32'hefe00000
`define GBW_MMIO_MASK     32'hffe00000

`define GBW_ADDR_RESET    32'h00000000
`endif

// [hw/gbw_delay.sv]
// Fixed-length delay line with clock enable and synchronous clear
`timescale 1ns/1ps
module gbw_delay #(
  parameter int W = 1,
  parameter int N = 1
) (
  input  wire logic         clk_in,   // Core clock
  input  wire logic         reset_in, // Sync reset, high
  input  wire logic         ce_in,    // Freeze when low
  input  wire logic [W-1:0] d_in,     // Stage input
  output logic      [W-1:0] q_out     // Output after N edges
);
  logic [W-1:0] stage_r   [N];
  logic [W-1:0] stage_nxt [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_stage
      if (g == 0) begin : g_head
        always_comb begin
          stage_nxt[g] = d_in;
        end
      end else begin : g_body
        always_comb begin
          stage_nxt[g] = stage_r[g-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < N; i++) begin
      if (reset_in) begin
        stage_r[i] <= '0;
      end else if (ce_in) begin
        stage_r[i] <= stage_nxt[i];
      end
    end
  end

  assign q_out = stage_r[N-1];
endmodule

// [hw/gbw_top.sv]
// Guarded jump unit and guarded 32-bit word-load unit of the core
`timescale 1ns/1ps
`include "gbw_regs.svh"
module gbw_top (
  input  wire logic              CLK_IN,                 // Core clock, 40 MHz
  input  wire logic              RESET_IN,               // Sync reset, high
  input  wire logic              CE_IN,                  // Clock enable, freezes all
  input  wire logic              BR_VALID_IN,            // Branch slot issue
  input  gbw_pkg::gbw_opc_t      BR_OPCODE_IN,           // Branch opcode
  input  wire logic              BR_GUARD_EN_IN,         // Guard register supplied
  input  wire logic              BR_GUARD_LSB_IN,        // Guard bit 0
  input  wire logic              BR_FIRST_SOURCE_LSB_IN, // Condition bit 0
  input  gbw_pkg::gbw_word_t     BR_SECOND_SOURCE_IN,    // Register jump target
  input  gbw_pkg::gbw_word_t     BR_MODIFIER_IN,         // Immediate jump target
  output logic                   PC_LOAD_OUT,            // Load program counter
  output gbw_pkg::gbw_word_t     PC_TARGET_OUT,          // New program counter
  input  wire logic              LD_VALID_IN,            // Load slot issue
  input  gbw_pkg::gbw_opc_t      LD_OPCODE_IN,           // Load opcode
  input  wire logic              LD_GUARD_EN_IN,         // Guard register supplied
  input  wire logic              LD_GUARD_LSB_IN,        // Guard bit 0
  input  gbw_pkg::gbw_word_t     LD_FIRST_SOURCE_IN,     // Base address
  input  gbw_pkg::gbw_disp_t     LD_MODIFIER_IN,         // Displacement field
  input  gbw_pkg::gbw_reg_t      LD_DEST_IN,             // Destination register
  input  wire logic              BYTE_ORDER_FLAG_IN,     // 1 little, 0 big endian
  output logic                   MEM_REQ_OUT,            // Memory read request
  output gbw_pkg::gbw_word_t     MEM_ADDR_OUT,           // Effective address
  output logic                   MEM_CACHE_UPD_OUT,      // Cache status may update
  output logic                   MEM_MMIO_OUT,           // Address in I/O aperture
  input  gbw_pkg::gbw_word_t     MEM_RDATA_IN,           // Bytes addr+k in lane k
  output logic                   RF_WE_OUT,              // Destination write
  output gbw_pkg::gbw_reg_t      RF_WADDR_OUT,           // Destination index
  output gbw_pkg::gbw_word_t     RF_WDATA_OUT            // Loaded word
);
  import gbw_pkg::*;

  // Branch decode
  gbw_br_kind_t br_kind;
  logic         br_guard_ok;
  logic         br_take;
  gbw_word_t    br_target;
  logic [32:0]  br_q;

  always_comb begin
    br_kind = GBW_BR_NONE;
    if (BR_VALID_IN) begin
      if (BR_OPCODE_IN == `GBW_OP_JUMP_FALSE) begin
        br_kind = GBW_BR_FALSE;
      end else if (BR_OPCODE_IN == `GBW_OP_JUMP_TRUE) begin
        br_kind = GBW_BR_TRUE;
      end else if (BR_OPCODE_IN == `GBW_OP_JUMP_IMM) begin
        br_kind = GBW_BR_IMM;
      end
    end
  end

  assign br_guard_ok = !BR_GUARD_EN_IN || BR_GUARD_LSB_IN;

  always_comb begin
    br_take   = 1'b0;
    br_target = BR_SECOND_SOURCE_IN;
    unique case (br_kind)
      GBW_BR_NONE: begin
        br_take = 1'b0;
      end
      GBW_BR_FALSE: begin
        br_take = br_guard_ok && !BR_FIRST_SOURCE_LSB_IN;
      end
      GBW_BR_TRUE: begin
        br_take = br_guard_ok && BR_FIRST_SOURCE_LSB_IN;
      end
      GBW_BR_IMM: begin
        br_take   = br_guard_ok;
        br_target = BR_MODIFIER_IN;
      end
    endcase
  end

  gbw_delay #(
    .W (33),
    .N (`GBW_BR_DELAY)
  ) u_br_delay (
    .clk_in   (CLK_IN),
    .reset_in (RESET_IN),
    .ce_in    (CE_IN),
    .d_in     ({br_take, br_target}),
    .q_out    (br_q)
  );

  assign PC_LOAD_OUT   = br_q[32];
  assign PC_TARGET_OUT = br_q[31:0];

  // Load address stage
  logic      ld_guard_ok;
  logic      ld_fire;
  gbw_word_t ld_disp;
  gbw_word_t ld_addr;
  logic      ld_mmio;
  gbw_swap_t ld_swap;

  assign ld_guard_ok = !LD_GUARD_EN_IN || LD_GUARD_LSB_IN;
  assign ld_fire     = LD_VALID_IN && (LD_OPCODE_IN == `GBW_OP_WORD_LOAD) && ld_guard_ok;

  always_comb begin
    ld_disp = {{`GBW_DISP_EXT_W{LD_MODIFIER_IN[`GBW_DISP_MSB]}}, LD_MODIFIER_IN, 2'b00};
    ld_addr = LD_FIRST_SOURCE_IN + ld_disp;
    ld_mmio = (ld_addr & `GBW_MMIO_MASK) == `GBW_MMIO_BASE;
    // aperture reads pass the word as is
    if (ld_mmio || BYTE_ORDER_FLAG_IN) begin
      ld_swap = `GBW_SWAP_LITTLE;
    end else begin
      ld_swap = `GBW_SWAP_BIG;
    end
  end

  // Load pipeline: request, data capture, write back
  logic      req_r,   req_nxt;
  gbw_word_t addr_r,  addr_nxt;
  logic      cupd_r,  cupd_nxt;
  logic      mmio_r,  mmio_nxt;
  gbw_reg_t  dest1_r, dest1_nxt;
  gbw_swap_t swap1_r, swap1_nxt;
  logic      v2_r,    v2_nxt;
  gbw_reg_t  dest2_r, dest2_nxt;
  gbw_swap_t swap2_r, swap2_nxt;
  logic      we_r,    we_nxt;
  gbw_reg_t  waddr_r, waddr_nxt;
  gbw_word_t wdata_r, wdata_nxt;
  gbw_word_t ordered_w;

  // lane i from byte ((3-i) xor s)
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      logic [1:0] src_sel;
      assign src_sel = 2'(3 - lane) ^ swap2_r;
      assign ordered_w[8*lane +: 8] = MEM_RDATA_IN[{src_sel, 3'b000} +: 8];
    end
  endgenerate

  always_comb begin
    req_nxt   = ld_fire;
    // Aperture is never cacheable, so its status bits stay put
    // cache status only on enabled load
    cupd_nxt  = ld_fire && !ld_mmio;
    mmio_nxt  = ld_fire && ld_mmio;
    // low address bits go out untouched, no fault path
    addr_nxt  = ld_fire ? ld_addr : addr_r;
    dest1_nxt = ld_fire ? LD_DEST_IN : dest1_r;
    swap1_nxt = ld_fire ? ld_swap : swap1_r;
    v2_nxt    = req_r;
    dest2_nxt = dest1_r;
    swap2_nxt = swap1_r;
    we_nxt    = v2_r;
    waddr_nxt = v2_r ? dest2_r : waddr_r;
    wdata_nxt = v2_r ? ordered_w : wdata_r;
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      req_r   <= 1'b0;
      addr_r  <= `GBW_ADDR_RESET;
      cupd_r  <= 1'b0;
      mmio_r  <= 1'b0;
      dest1_r <= '0;
      swap1_r <= `GBW_SWAP_BIG;
      v2_r    <= 1'b0;
      dest2_r <= '0;
      swap2_r <= `GBW_SWAP_BIG;
      we_r    <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else if (CE_IN) begin
      req_r   <= req_nxt;
      addr_r  <= addr_nxt;
      cupd_r  <= cupd_nxt;
      mmio_r  <= mmio_nxt;
      dest1_r <= dest1_nxt;
      swap1_r <= swap1_nxt;
      v2_r    <= v2_nxt;
      dest2_r <= dest2_nxt;
      swap2_r <= swap2_nxt;
      we_r    <= we_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign MEM_REQ_OUT       = req_r;
  assign MEM_ADDR_OUT      = addr_r;
  assign MEM_CACHE_UPD_OUT = cupd_r;
  assign MEM_MMIO_OUT      = mmio_r;
  assign RF_WE_OUT         = we_r;
  assign RF_WADDR_OUT      = waddr_r;
  assign RF_WDATA_OUT      = wdata_r;

  // Checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  gbw_word_t rdata_rev_chk;
  assign rdata_rev_chk = {MEM_RDATA_IN[7:0], MEM_RDATA_IN[15:8],
                          MEM_RDATA_IN[23:16], MEM_RDATA_IN[31:24]};

  sequence s_ce3;
    CE_IN [*3];
  endsequence

  sequence s_jf_go;
    BR_VALID_IN && BR_OPCODE_IN == `GBW_OP_JUMP_FALSE && !BR_GUARD_EN_IN
      && !BR_FIRST_SOURCE_LSB_IN;
  endsequence

  sequence s_jt_go;
    BR_VALID_IN && BR_OPCODE_IN == `GBW_OP_JUMP_TRUE && BR_GUARD_EN_IN
      && BR_GUARD_LSB_IN && BR_FIRST_SOURCE_LSB_IN;
  endsequence

  sequence s_ld_go;
    LD_VALID_IN && LD_OPCODE_IN == `GBW_OP_WORD_LOAD && ld_guard_ok;
  endsequence

  a_jump_false_taken: assert property (
    s_jf_go ##0 s_ce3 |=> PC_LOAD_OUT && PC_TARGET_OUT == $past(BR_SECOND_SOURCE_IN, 3))
    else $error("jump on false did not load the target after three");

  a_jump_true_taken: assert property (
    s_jt_go ##0 s_ce3 |=> PC_LOAD_OUT && PC_TARGET_OUT == $past(BR_SECOND_SOURCE_IN, 3))
    else $error("jump on true did not load the target after three");

  a_jump_imm_taken: assert property (
    (BR_VALID_IN && BR_OPCODE_IN == `GBW_OP_JUMP_IMM && br_guard_ok) ##0 s_ce3
      |=> PC_LOAD_OUT && PC_TARGET_OUT == $past(BR_MODIFIER_IN, 3))
    else $error("immediate jump target wrong");

  a_jump_guard_off: assert property (
    (BR_VALID_IN && BR_GUARD_EN_IN && !BR_GUARD_LSB_IN) ##0 s_ce3 |=> !PC_LOAD_OUT)
    else $error("jump taken with guard clear");

  a_load_offset_addr: assert property (
    s_ld_go ##0 CE_IN |=> MEM_REQ_OUT
      && $signed(MEM_ADDR_OUT - $past(LD_FIRST_SOURCE_IN))
         == 4 * $signed($past(LD_MODIFIER_IN)))
    else $error("displaced load address wrong");

  a_load_plain_addr: assert property (
    s_ld_go ##0 (CE_IN && LD_MODIFIER_IN == '0)
      |=> MEM_REQ_OUT && MEM_ADDR_OUT == $past(LD_FIRST_SOURCE_IN))
    else $error("plain load address not the source register");

  a_load_byte_order: assert property (
    s_ld_go ##0 (!ld_mmio) ##0 s_ce3 |=> RF_WE_OUT && RF_WDATA_OUT ==
      ($past(BYTE_ORDER_FLAG_IN, 3) ? $past(MEM_RDATA_IN) : $past(rdata_rev_chk)))
    else $error("byte lanes of loaded word misordered");

  a_load_misaligned: assert property (
    s_ld_go ##0 (CE_IN && ld_addr[1:0] != 2'b00) |=> MEM_REQ_OUT ##2 RF_WE_OUT)
    else $error("misaligned load not carried through");

  a_mmio_no_swap: assert property (
    s_ld_go ##0 (ld_mmio) ##0 s_ce3
      |=> RF_WE_OUT && RF_WDATA_OUT == $past(MEM_RDATA_IN))
    else $error("aperture load was byte swapped");

  a_load_latency: assert property (
    s_ld_go ##0 s_ce3 |=> RF_WE_OUT
      && RF_WADDR_OUT == $past(LD_DEST_IN, 3) && $past(MEM_REQ_OUT, 2))
    else $error("load result not written three cycles after issue");

  a_load_guard_off: assert property (
    (LD_VALID_IN && LD_GUARD_EN_IN && !LD_GUARD_LSB_IN) ##0 s_ce3
      |=> !$past(MEM_REQ_OUT, 2) && !$past(MEM_CACHE_UPD_OUT, 2) && !RF_WE_OUT)
    else $error("suppressed load had a side effect");

  a_load_no_guard: assert property (
    (LD_VALID_IN && LD_OPCODE_IN == `GBW_OP_WORD_LOAD && !LD_GUARD_EN_IN && CE_IN)
      |=> MEM_REQ_OUT)
    else $error("unguarded load not issued");
endmodule

// [testbench/gbw_mem_model.sv]
// Behavioural data memory that answers the block's word reads
`timescale 1ns/1ps
module gbw_mem_model (
  input  wire logic          clk_in,    // Core clock
  input  wire logic          ce_in,     // Clock enable
  input  wire logic          req_in,    // Read request pulse
  input  gbw_pkg::gbw_word_t addr_in,   // Byte address
  output gbw_pkg::gbw_word_t rdata_out  // Byte addr+k in lane k
);
  import gbw_pkg::*;
  gbw_word_t rdata_r = 32'h0;

  // Distinct byte per address so lane mix-ups show
  function automatic logic [7:0] mem_byte(input gbw_word_t a);
    return a[7:0] ^ 8'h5c;
  endfunction

  always_ff @(posedge clk_in) begin
    if (ce_in && req_in) begin
      for (int k = 0; k < 4; k++) begin
        rdata_r[8*k +: 8] <= mem_byte(addr_in + k);
      end
    end else if (ce_in) begin
      // Stale data is scrambled, never left looking valid
      rdata_r <= ~rdata_r;
    end
  end
  assign rdata_out = rdata_r;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the guarded jump and word-load block
`timescale 1ns/1ps
`include "gbw_regs.svh"
module tb_top;
  import gbw_pkg::*;
  logic      clk        = 1'b0;
  logic      rst        = 1'b1;
  logic      ce         = 1'b1;
  logic      br_valid   = 1'b0;
  gbw_opc_t  br_op      = 8'h00;
  logic      br_gen     = 1'b0;
  logic      br_glsb    = 1'b0;
  logic      br_cond    = 1'b0;
  gbw_word_t br_src2    = 32'h0;
  gbw_word_t br_mod     = 32'h0;
  logic      ld_valid   = 1'b0;
  gbw_opc_t  ld_op      = 8'h00;
  logic      ld_gen     = 1'b0;
  logic      ld_glsb    = 1'b0;
  gbw_word_t ld_base    = 32'h0;
  gbw_disp_t ld_mod     = 7'h00;
  gbw_reg_t  ld_dest    = 7'h00;
  logic      order_flag = 1'b0;
  logic      pc_load, mem_req, cache_upd, mmio, rf_we;
  gbw_word_t pc_target, mem_addr, rdata, rf_wdata;
  gbw_reg_t  rf_waddr;
  int        err_total  = 0;
  int        n_tests    = 0;
  int        cyc        = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  gbw_top gbw_top_i (
    .CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce),
    .BR_VALID_IN(br_valid), .BR_OPCODE_IN(br_op), .BR_GUARD_EN_IN(br_gen),
    .BR_GUARD_LSB_IN(br_glsb), .BR_FIRST_SOURCE_LSB_IN(br_cond),
    .BR_SECOND_SOURCE_IN(br_src2), .BR_MODIFIER_IN(br_mod),
    .PC_LOAD_OUT(pc_load), .PC_TARGET_OUT(pc_target),
    .LD_VALID_IN(ld_valid), .LD_OPCODE_IN(ld_op), .LD_GUARD_EN_IN(ld_gen),
    .LD_GUARD_LSB_IN(ld_glsb), .LD_FIRST_SOURCE_IN(ld_base), .LD_MODIFIER_IN(ld_mod),
    .LD_DEST_IN(ld_dest), .BYTE_ORDER_FLAG_IN(order_flag),
    .MEM_REQ_OUT(mem_req), .MEM_ADDR_OUT(mem_addr), .MEM_CACHE_UPD_OUT(cache_upd),
    .MEM_MMIO_OUT(mmio), .MEM_RDATA_IN(rdata),
    .RF_WE_OUT(rf_we), .RF_WADDR_OUT(rf_waddr), .RF_WDATA_OUT(rf_wdata)
  );

  gbw_mem_model gbw_mem_model_i (
    .clk_in(clk), .ce_in(ce), .req_in(mem_req), .addr_in(mem_addr), .rdata_out(rdata)
  );

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 110 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk_bit(input string name, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %0h seen %0h", name, e, g);
      err_total++;
    end
  endtask

  task automatic chk_word(input string name, input gbw_word_t e, input gbw_word_t g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %0h seen %0h", name, e, g);
      err_total++;
    end
  endtask

  // Decoy in the unused target source catches a wrong source pick
  task automatic do_branch(input gbw_opc_t op, input logic gen, input logic glsb,
                           input logic cond, input gbw_word_t tgt, input logic take);
    @(posedge clk);
    br_valid <= 1'b1;
    br_op    <= op;
    br_gen   <= gen;
    br_glsb  <= glsb;
    br_cond  <= cond;
    br_src2  <= (op == `GBW_OP_JUMP_IMM) ? ~tgt : tgt;
    br_mod   <= (op == `GBW_OP_JUMP_IMM) ? tgt : ~tgt;
    for (int k = 1; k <= 4; k++) begin
      @(posedge clk);
      br_valid <= 1'b0;
      #1;
      chk_bit("pc_load", take && k == 3, pc_load);
      if (take && k == 3) begin
        chk_word("pc_target", tgt, pc_target);
      end
    end
  endtask

  task automatic do_load(input gbw_opc_t op, input logic gen, input logic glsb,
                         input gbw_word_t base, input gbw_disp_t dsp, input logic flag,
                         input logic go);
    gbw_word_t addr;
    gbw_word_t exp;
    logic      io;
    int        s;
    addr = base + 32'($signed(dsp) * 4);
    io   = (addr & `GBW_MMIO_MASK) == `GBW_MMIO_BASE;
    s    = (io || flag) ? 3 : 0;
    for (int i = 0; i < 4; i++) begin
      exp[8*i +: 8] = 8'(addr + 32'((3 - i) ^ s)) ^ 8'h5c;
    end
    @(posedge clk);
    ld_valid   <= 1'b1;
    ld_op      <= op;
    ld_gen     <= gen;
    ld_glsb    <= glsb;
    ld_base    <= base;
    ld_mod     <= dsp;
    ld_dest    <= dsp ^ 7'h2a;
    order_flag <= flag;
    for (int k = 1; k <= 3; k++) begin
      @(posedge clk);
      ld_valid <= 1'b0;
      #1;
      chk_bit("mem_req", go && k == 1, mem_req);
      chk_bit("rf_we", go && k == 3, rf_we);
      if (k == 1) begin
        chk_bit("cache_upd", go && !io, cache_upd);
        chk_bit("mmio", go && io, mmio);
      end
      if (go && k == 1) begin
        chk_word("mem_addr", addr, mem_addr);
      end
      if (go && k == 3) begin
        chk_word("rf_wdata", exp, rf_wdata);
        chk_word("rf_waddr", {25'h0, dsp ^ 7'h2a}, {25'h0, rf_waddr});
      end
    end
  endtask

  // Clock enable low must freeze both slots; results after three enabled edges
  task automatic do_stall();
    gbw_word_t exp;
    for (int i = 0; i < 4; i++) begin
      exp[8*i +: 8] = 8'(32'h00000d40 + 32'(3 - i)) ^ 8'h5c;
    end
    @(posedge clk);
    br_valid   <= 1'b1;
    br_op      <= `GBW_OP_JUMP_IMM;
    br_gen     <= 1'b0;
    br_mod     <= 32'h00001234;
    ld_valid   <= 1'b1;
    ld_op      <= `GBW_OP_WORD_LOAD;
    ld_gen     <= 1'b0;
    ld_base    <= 32'h00000d40;
    ld_mod     <= 7'h00;
    ld_dest    <= 7'h15;
    order_flag <= 1'b0;
    for (int k = 1; k <= 6; k++) begin
      @(posedge clk);
      br_valid <= 1'b0;
      ld_valid <= 1'b0;
      ce       <= (k == 1 || k == 2) ? 1'b0 : 1'b1;
      #1;
      chk_bit("mem_req", k <= 3, mem_req);
      chk_bit("pc_load", k == 5, pc_load);
      chk_bit("rf_we", k == 5, rf_we);
      if (k == 5) begin
        chk_word("pc_target", 32'h00001234, pc_target);
        chk_word("rf_wdata", exp, rf_wdata);
      end
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    do_branch(`GBW_OP_JUMP_FALSE, 1'b0, 1'b0, 1'b0, 32'h330, 1'b1);
    do_branch(`GBW_OP_JUMP_FALSE, 1'b0, 1'b1, 1'b1, 32'h330, 1'b0);
    do_branch(`GBW_OP_JUMP_FALSE, 1'b1, 1'b0, 1'b0, 32'h8000, 1'b0);
    do_branch(`GBW_OP_JUMP_FALSE, 1'b1, 1'b1, 1'b0, 32'h8000, 1'b1);
    do_branch(`GBW_OP_JUMP_TRUE, 1'b0, 1'b0, 1'b1, 32'h330, 1'b1);
    do_branch(`GBW_OP_JUMP_TRUE, 1'b0, 1'b1, 1'b0, 32'h330, 1'b0);
    do_branch(`GBW_OP_JUMP_TRUE, 1'b1, 1'b0, 1'b1, 32'h8000, 1'b0);
    do_branch(`GBW_OP_JUMP_TRUE, 1'b1, 1'b1, 1'b1, 32'h8000, 1'b1);
    do_branch(`GBW_OP_JUMP_IMM, 1'b0, 1'b0, 1'b1, 32'hffffffff, 1'b1);
    do_branch(`GBW_OP_JUMP_IMM, 1'b1, 1'b0, 1'b0, 32'h8000, 1'b0);
    do_branch(`GBW_OP_JUMP_IMM, 1'b1, 1'b1, 1'b0, 32'h8000, 1'b1);
    do_branch(8'hb1, 1'b0, 1'b0, 1'b1, 32'h330, 1'b0);
    do_load(`GBW_OP_WORD_LOAD, 1'b0, 1'b0, 32'hd00, 7'h00, 1'b0, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b0, 1'b1, 32'hcfc, 7'h01, 1'b0, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b1, 1'b1, 32'hd0c, 7'h7e, 1'b1, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b0, 1'b1, 32'h1000, 7'h40, 1'b0, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b0, 1'b1, 32'h2000, 7'h3f, 1'b1, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b1, 1'b0, 32'hd04, 7'h00, 1'b0, 1'b0);
    do_load(`GBW_OP_WORD_LOAD, 1'b0, 1'b1, 32'hd01, 7'h00, 1'b1, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b0, 1'b1, 32'hefe00010, 7'h00, 1'b0, 1'b1);
    do_load(`GBW_OP_WORD_LOAD, 1'b1, 1'b1, 32'hefe00020, 7'h7f, 1'b1, 1'b1);
    do_load(8'hc8, 1'b0, 1'b1, 32'hd00, 7'h00, 1'b0, 1'b0);
    do_stall();
    close_out();
  end
endmodule
